// ---- common/pll_clock_map.svh ----
// Register offsets, field positions, reset values and timing counts of the clock control.
`ifndef PLL_CLOCK_MAP_SVH
`define PLL_CLOCK_MAP_SVH

// ==========================================================================
// Control register location and layout
// ==========================================================================
`define PLL_CTRL_ADDR 8'hD7
`define PLL_CTRL_RESET 8'h53
`define OSC_POWERDOWN_BIT 7
`define LOCK_BIT 6
`define UNUSED_BIT 5
`define EXT_ACCESS_BIT 4
`define FAST_IRQ_BIT 3
`define DIV_MSB 2
`define DIV_LSB 0

// Reset values of the individual fields, matching the whole-register default.
`define OSC_POWERDOWN_RESET 1'b0
`define EXT_ACCESS_RESET 1'b1
`define FAST_IRQ_RESET 1'b0
`define DIV_RESET 3'h3

// ==========================================================================
// Frequencies and derived counts
// ==========================================================================
`define REF_CLK_HZ 25000000
`define XTAL_HZ 32768
`define PLL_MULT 384
`define PLL_HZ (`XTAL_HZ * `PLL_MULT)
`define NCO_W 24
`define NCO_INC_NOM (24'((64'(`PLL_HZ) << `NCO_W) / 64'(`REF_CLK_HZ)))
`define NCO_INC_MIN (24'((64'(`NCO_INC_NOM) * 64'd8) / 64'd10))
`define NCO_INC_MAX (24'((64'(`NCO_INC_NOM) * 64'd12) / 64'd10))
`define NCO_STEP 24'h000100
`define LOCK_TOL 10'h001
`define LOCK_GOOD_RUNS 2'h3
`define LOCK_TIMEOUT 10'h300
`define CORE_CNT_W 7
`define MOD_LAST 9'h17F

`endif

// ---- common/pll_clock_pkg.sv ----
// Types shared by the clock control modules.
package pll_clock_pkg;

   // =======================================================================
   // Bus request and clock-enable bundles
   // =======================================================================
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

   typedef struct packed {
      logic pll;
      logic core;
      logic mod;
   } clk_ticks_type;

   // Lock tracker states, Gray coded along search, track, locked.
   typedef enum logic [1:0] {
      LOCK_SEARCH = 2'h0,
      LOCK_TRACK = 2'h1,
      LOCK_LOCKED = 2'h3
   } lock_state_type;

endpackage

// ---- verilog/pll_tracker.sv ----
// Digital phase tracker: an NCO slaved to the crystal, with a lock detector.
`include "pll_clock_map.svh"

module pll_tracker (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Crystal edge.
   input wire logic xtal_rise_i,
   // Outputs.
   output logic pll_tick_o,
   output logic lock_o
);
   import pll_clock_pkg::*;

   logic [`NCO_W-1:0] acc_reg;
   logic [`NCO_W-1:0] inc_reg;
   logic [`NCO_W:0] sum;
   logic [9:0] per_cnt_reg;
   logic [1:0] good_reg;
   lock_state_type state_reg;
   logic timeout;
   logic in_tol;

   // ========================================================================
   // Oscillator
   // ========================================================================
   // The accumulator carry is one tick of the multiplied clock.
   assign sum = {1'b0, acc_reg} + {1'b0, inc_reg};

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_reg <= '0;
         pll_tick_o <= 1'b0;
      end else begin
         acc_reg <= sum[`NCO_W-1:0];
         pll_tick_o <= sum[`NCO_W];
      end
   end

   // ========================================================================
   // Period measurement
   // ========================================================================
   // Ticks counted per crystal period; saturates so a missing crystal times out.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         per_cnt_reg <= '0;
      end else if (xtal_rise_i) begin
         per_cnt_reg <= {9'h000, pll_tick_o};
      end else if (pll_tick_o && !timeout) begin
         per_cnt_reg <= per_cnt_reg + 10'h001;
      end
   end

   assign timeout = (per_cnt_reg >= `LOCK_TIMEOUT);
   assign in_tol = (per_cnt_reg >= 10'(`PLL_MULT) - `LOCK_TOL) &&
                   (per_cnt_reg <= 10'(`PLL_MULT) + `LOCK_TOL);

   // ========================================================================
   // Frequency correction
   // ========================================================================
   // Nudge the increment toward 384 ticks per period, clamped to 20 percent.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         inc_reg <= `NCO_INC_NOM;
      end else if (timeout) begin
         inc_reg <= `NCO_INC_NOM;
      end else if (xtal_rise_i && state_reg != LOCK_SEARCH) begin
         if (per_cnt_reg < 10'(`PLL_MULT) && inc_reg < `NCO_INC_MAX) begin
            inc_reg <= inc_reg + `NCO_STEP;
         end else if (per_cnt_reg > 10'(`PLL_MULT) && inc_reg > `NCO_INC_MIN) begin
            inc_reg <= inc_reg - `NCO_STEP;
         end
      end
   end

   // ========================================================================
   // Lock detector
   // ========================================================================
   // Four good periods in a row declare lock; a bad period or timeout drops it.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= LOCK_SEARCH;
         good_reg <= '0;
      end else begin
         unique case (state_reg)
            LOCK_SEARCH: begin
               good_reg <= '0;
               if (xtal_rise_i) begin
                  state_reg <= LOCK_TRACK;
               end
            end
            LOCK_TRACK: begin
               if (timeout) begin
                  state_reg <= LOCK_SEARCH;
               end else if (xtal_rise_i && in_tol) begin
                  good_reg <= good_reg + 2'h1;
                  if (good_reg == `LOCK_GOOD_RUNS) begin
                     state_reg <= LOCK_LOCKED;
                  end
               end else if (xtal_rise_i) begin
                  good_reg <= '0;
               end
            end
            LOCK_LOCKED: begin
               if (timeout || (xtal_rise_i && !in_tol)) begin
                  state_reg <= timeout ? LOCK_SEARCH : LOCK_TRACK;
                  good_reg <= '0;
               end
            end
            default: begin
               state_reg <= LOCK_SEARCH;
            end
         endcase
      end
   end

   assign lock_o = (state_reg == LOCK_LOCKED);

endmodule

// ---- verilog/core_clock_divider.sv ----
// Glitch-free binary divider producing the core clock enable from PLL ticks.
`include "pll_clock_map.svh"

module core_clock_divider (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Source tick and requested divide code.
   input wire logic pll_tick_i,
   input wire logic [2:0] code_i,
   // Outputs.
   output logic core_tick_o,
   output logic [2:0] active_code_o
);
   import pll_clock_pkg::*;

   logic [`CORE_CNT_W-1:0] cnt_reg;
   logic [`CORE_CNT_W-1:0] mask;

   // Low bits that must be zero for a core tick under the active code.
   assign mask = `CORE_CNT_W'((1 << active_code_o) - 1);

   // Free-running tick counter.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg <= '0;
      end else if (pll_tick_i) begin
         cnt_reg <= cnt_reg + `CORE_CNT_W'(1);
      end
   end

   // A new code only takes over where every period ends, so no runt period occurs.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         active_code_o <= `DIV_RESET;
      end else if (pll_tick_i && cnt_reg == '0) begin
         active_code_o <= code_i;
      end
   end

   // Core enable every 2^code PLL ticks.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_tick_o <= 1'b0;
      end else begin
         core_tick_o <= pll_tick_i && ((cnt_reg & mask) == '0);
      end
   end

endmodule

// ---- verilog/pll_clock_control.sv ----
// Clock control: PLL tracking, core divider, converter clock and the control register.
//
// What this block does
// - Multiply the 32.768 kHz crystal by 384 to a 12.582912 MHz tick.
// - Core clock is PLL output divided by a power of two.
// - After reset the core clock is PLL divided by 8.
// - Converter modulator tick derives from PLL, at the crystal rate.
// - Divider bits 2..0 halve the core rate per step, code 0 to 7.
// - Bit 7 clear keeps oscillator running in power-down; set stops it.
// - In normal mode the oscillator always runs.
// - Lock flag bit 6 is read-only; writes do not touch it.
// - Lock flag sets when the loop tracks the crystal.
// - Lock flag clears without tracking; output free-runs within 20 percent.
// - Bit 5 unimplemented; writes ignored, reads zero.
// - Bit 4 returns the external access pin level caught at reset.
// - Fast-interrupt bit set runs interrupts at the fastest core rate.
// - Fast-interrupt bit clear runs interrupts at the programmed rate.
`include "pll_clock_map.svh"

module pll_clock_control (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Crystal and chip state.
   input wire logic xtal_i,
   input wire logic powerdown_i,
   input wire logic irq_active_i,
   input wire logic external_access_pin_i,
   // Special-function register port.
   input wire pll_clock_pkg::sfr_req_type sfr_i,
   output logic [7:0] sfr_rdata_o,
   // Clock enables and oscillator control.
   output pll_clock_pkg::clk_ticks_type ticks_o,
   output logic osc_enable_o
);
   import pll_clock_pkg::*;

   logic xtal_prev_reg;
   logic xtal_rise;
   logic pll_tick;
   logic pll_lock;
   logic core_tick;
   logic [2:0] active_code;
   logic [2:0] effective_code;
   logic [8:0] mod_cnt_reg;
   logic mod_tick_reg;
   logic oscillator_powerdown_reg;
   logic fast_irq_response_reg;
   logic [2:0] core_divider_reg;
   logic latched_ext_access_reg;
   logic captured_reg;
   logic reg_hit;
   logic [7:0] pll_control;

   // ========================================================================
   // Crystal edge detection
   // ========================================================================
   // The crystal input is taken as synchronous, so one register suffices.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         xtal_prev_reg <= 1'b0;
      end else begin
         xtal_prev_reg <= xtal_i;
      end
   end

   assign xtal_rise = xtal_i && !xtal_prev_reg;

   // ========================================================================
   // PLL and core divider
   // ========================================================================
   pll_tracker u_tracker (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .xtal_rise_i(xtal_rise),
      .pll_tick_o(pll_tick),
      .lock_o(pll_lock)
   );

   // During an interrupt with fast response the fastest code is forced.
   assign effective_code = (fast_irq_response_reg && irq_active_i) ? 3'h0 : core_divider_reg;

   core_clock_divider u_divider (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .pll_tick_i(pll_tick),
      .code_i(effective_code),
      .core_tick_o(core_tick),
      .active_code_o(active_code)
   );

   // ========================================================================
   // Converter modulator clock
   // ========================================================================
   // One modulator tick per 384 PLL ticks lands at the crystal rate once locked.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mod_cnt_reg <= '0;
         mod_tick_reg <= 1'b0;
      end else begin
         mod_tick_reg <= pll_tick && (mod_cnt_reg == `MOD_LAST);
         if (pll_tick) begin
            mod_cnt_reg <= (mod_cnt_reg == `MOD_LAST) ? 9'h000 : mod_cnt_reg + 9'h001;
         end
      end
   end

   assign ticks_o.pll = pll_tick;
   assign ticks_o.core = core_tick;
   assign ticks_o.mod = mod_tick_reg;

   // ========================================================================
   // Oscillator enable
   // ========================================================================
   // Only the power-down mode with the bit set stops the crystal.
   assign osc_enable_o = !(powerdown_i && oscillator_powerdown_reg);

   // ========================================================================
   // Control register
   // ========================================================================
   assign reg_hit = (sfr_i.addr == `PLL_CTRL_ADDR);

   // Writable fields; bit 6, bit 5 and bit 4 of the write data are dropped.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oscillator_powerdown_reg <= `OSC_POWERDOWN_RESET;
         fast_irq_response_reg <= `FAST_IRQ_RESET;
         core_divider_reg <= `DIV_RESET;
      end else if (sfr_i.wr && reg_hit) begin
         oscillator_powerdown_reg <= sfr_i.wdata[`OSC_POWERDOWN_BIT];
         fast_irq_response_reg <= sfr_i.wdata[`FAST_IRQ_BIT];
         core_divider_reg <= sfr_i.wdata[`DIV_MSB:`DIV_LSB];
      end
   end

   // The pin is caught at the first edge after reset release and then held.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         latched_ext_access_reg <= `EXT_ACCESS_RESET;
         captured_reg <= 1'b0;
      end else if (!captured_reg) begin
         latched_ext_access_reg <= external_access_pin_i;
         captured_reg <= 1'b1;
      end
   end

   // Read image; the unimplemented bit reads zero.
   always_comb begin
      pll_control = 8'h00;
      pll_control[`OSC_POWERDOWN_BIT] = oscillator_powerdown_reg;
      pll_control[`LOCK_BIT] = pll_lock;
      pll_control[`EXT_ACCESS_BIT] = latched_ext_access_reg;
      pll_control[`FAST_IRQ_BIT] = fast_irq_response_reg;
      pll_control[`DIV_MSB:`DIV_LSB] = core_divider_reg;
   end

   // Read data is registered; other addresses and idle cycles return zero.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_i.rd && reg_hit) begin
         sfr_rdata_o <= pll_control;
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

   // ========================================================================
   // Checks
   // ========================================================================
   // Helper: PLL ticks between successive core ticks and the code they ran at.
   logic [7:0] gap_reg;
   logic [2:0] gap_code_reg;
   logic gap_valid_reg;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_reg <= 8'h00;
         gap_code_reg <= 3'h0;
         gap_valid_reg <= 1'b0;
      end else if (core_tick) begin
         gap_reg <= {7'h00, pll_tick};
         gap_code_reg <= active_code;
         gap_valid_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + {7'h00, pll_tick};
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_reg_read;
      sfr_i.rd && reg_hit;
   endsequence

   sequence s_reg_write;
      sfr_i.wr && reg_hit && !sfr_i.rd;
   endsequence

   a_core_period: assert property (core_tick && gap_valid_reg |->
      gap_reg == (8'h01 << gap_code_reg))
      else $error("core tick period is not a whole divided period");

   // At code 0 the PLL rate is above half the reference, so back-to-back ticks are legal there.
   a_core_no_runt: assert property (core_tick && active_code != 3'h0 |=> !core_tick)
      else $error("core ticks back to back while divided");

   a_osc_normal_run: assert property (!powerdown_i |-> osc_enable_o)
      else $error("oscillator stopped in normal mode");

   a_oscillator_powerdown_stop: assert property (powerdown_i |->
      osc_enable_o == !oscillator_powerdown_reg)
      else $error("oscillator enable disagrees with power-down bit");

   a_fast_irq_code: assert property (fast_irq_response_reg && irq_active_i |->
      effective_code == 3'h0)
      else $error("fast interrupt response not at fastest code");

   a_slow_irq_code: assert property (!fast_irq_response_reg |->
      effective_code == core_divider_reg)
      else $error("interrupt rate differs from divider field");

   a_lock_read_back: assert property (s_reg_read |=>
      sfr_rdata_o[`LOCK_BIT] == $past(pll_lock) && !sfr_rdata_o[`UNUSED_BIT])
      else $error("lock or unimplemented bit read back wrong");

   a_write_fields: assert property (s_reg_write ##1 sfr_i.rd && reg_hit && !sfr_i.wr |=>
      sfr_rdata_o[`DIV_MSB:`DIV_LSB] == $past(sfr_i.wdata[`DIV_MSB:`DIV_LSB], 2))
      else $error("divider field did not take the written value");

   a_access_held: assert property (captured_reg |=> $stable(latched_ext_access_reg))
      else $error("latched access pin changed after capture");

   a_mod_from_pll: assert property (mod_tick_reg |-> $past(pll_tick))
      else $error("modulator tick not aligned to a PLL tick");

endmodule

// ---- sim/xtal_model.sv ----
// Watch crystal model that feeds the clock control with a 32.768 kHz level.
module xtal_model (
   // Clock.
   input wire logic ref_clk_i,
   // Oscillator enable from the device.
   input wire logic osc_enable_i,
   // Crystal level.
   output logic xtal_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic odd = 1'b0;
   initial xtal_o = 1'b0;
   // Half periods alternate 381 and 382 cycles, so a full period of 763 cycles
   // stays within one cycle of the true crystal period at 25 MHz.
   always @(negedge ref_clk_i) begin
      if (osc_enable_i === 1'b1) begin
         cnt <= cnt + 1;
         if (cnt >= 380 + int'(odd)) begin
            cnt <= 0;
            odd <= ~odd;
            xtal_o <= ~xtal_o;
         end
      end
   end
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench for the clock control block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pll_clock_pkg::*;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic xtal_i;
   logic powerdown_i = 1'b0;
   logic irq_active_i = 1'b0;
   logic external_access_pin_i = 1'b1;
   sfr_req_type sfr_i = '0;
   logic [7:0] sfr_rdata_o;
   clk_ticks_type ticks_o;
   logic osc_enable_o;
   logic [7:0] rdata;
   int num_errors = 0;
   int compares = 0;
   int pll_cnt = 0;
   int core_mark = 0;
   int core_gap = 0;
   int core_seen = 0;
   int mod_mark = 0;
   int mod_gap = 0;

   // ====================================================================
   // Clock, device and crystal
   // ====================================================================
   always #20 ref_clk_i = ~ref_clk_i;

   pll_clock_control pll_clock_control_inst (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .xtal_i(xtal_i),
      .powerdown_i(powerdown_i),
      .irq_active_i(irq_active_i),
      .external_access_pin_i(external_access_pin_i),
      .sfr_i(sfr_i),
      .sfr_rdata_o(sfr_rdata_o),
      .ticks_o(ticks_o),
      .osc_enable_o(osc_enable_o)
   );

   xtal_model xtal_model_inst (
      .ref_clk_i(ref_clk_i),
      .osc_enable_i(osc_enable_o),
      .xtal_o(xtal_i)
   );

   // ====================================================================
   // Shared tasks
   // ====================================================================
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   // Requests are held for exactly one rising edge, as the port takes them.
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk_i);
      sfr_i = '0;
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge ref_clk_i);
      sfr_i = '0;
      d = sfr_rdata_o;
   endtask

   // A write followed at the very next edge by a read of the same address.
   task automatic sfr_write_read(input logic [7:0] a, input logic [7:0] w,
                                 output logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
      @(negedge ref_clk_i);
      sfr_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge ref_clk_i);
      sfr_i = '0;
      d = sfr_rdata_o;
   endtask

   // Allows for the divider to reach its switch boundary before measuring.
   task automatic core_gap_is(input int exp);
      int n;
      cycles(600);
      n = core_seen;
      for (int i = 0; i < 2000 && core_seen < n + 2; i++) cycles(1);
      cmp("core tick gap", 16'(exp), 16'(core_gap));
   endtask

   task automatic pll_rate(input int lo, input int hi);
      int n;
      n = pll_cnt;
      cycles(1000);
      n = pll_cnt - n;
      cmp("pll ticks per 1000 cycles in range", 16'h0001, 16'(n >= lo && n <= hi));
   endtask

   task automatic wait_lock();
      for (int i = 0; i < 200; i++) begin
         sfr_read(8'hD7, rdata);
         if (rdata[6] === 1'b1) break;
         cycles(100);
      end
   endtask

   // Gaps are counted in PLL ticks; a runt would give a gap that is not a power of two.
   always @(posedge ref_clk_i) begin
      if (ticks_o.core === 1'b1) begin
         core_gap = pll_cnt - core_mark;
         core_mark = pll_cnt;
         if (core_seen > 0) cmp("core gap power of two", 16'h0001,
            16'(core_gap > 0 && core_gap <= 128 && (core_gap & (core_gap - 1)) == 0));
         core_seen++;
      end
      if (ticks_o.mod === 1'b1) begin
         mod_gap = pll_cnt - mod_mark;
         mod_mark = pll_cnt;
      end
      if (ticks_o.pll === 1'b1) pll_cnt++;
   end

   // ====================================================================
   // Tests
   // ====================================================================
   initial begin
      cycles(10);
      nrst_i = 1'b1;
      cycles(2);
      external_access_pin_i = 1'b0;
      sfr_read(8'hD7, rdata);
      cmp("control after reset", 16'h0013, 16'(rdata));
      core_gap_is(8);
      wait_lock();
      cmp("lock flag", 16'h0001, 16'(rdata[6]));
      pll_rate(502, 505);
      cmp("modulator gap", 16'd384, 16'(mod_gap));
      sfr_write_read(8'hD7, 8'hFF, rdata);
      cmp("control all ones", 16'h00DF, 16'(rdata));
      cmp("oscillator enable", 16'h0001, 16'(osc_enable_o));
      sfr_write(8'hD7, 8'h00);
      sfr_write(8'hD6, 8'h8B);
      sfr_read(8'hD7, rdata);
      cmp("control all zeros", 16'h0050, 16'(rdata));
      sfr_read(8'hD6, rdata);
      cmp("unmapped read", 16'h0000, 16'(rdata));
      // Every divider code; code 000 is allowed since this is a 5 V part.
      for (int c = 0; c < 8; c++) begin
         sfr_write(8'hD7, 8'(c));
         core_gap_is(1 << c);
      end
      sfr_write(8'hD7, 8'h0B);
      irq_active_i = 1'b1;
      core_gap_is(1);
      sfr_write(8'hD7, 8'h03);
      core_gap_is(8);
      irq_active_i = 1'b0;
      sfr_write(8'hD7, 8'h83);
      powerdown_i = 1'b1;
      cycles(1);
      cmp("oscillator enable", 16'h0000, 16'(osc_enable_o));
      cycles(2500);
      pll_rate(402, 604);
      sfr_read(8'hD7, rdata);
      cmp("lock flag", 16'h0000, 16'(rdata[6]));
      sfr_write(8'hD7, 8'h03);
      cycles(1);
      cmp("oscillator enable", 16'h0001, 16'(osc_enable_o));
      powerdown_i = 1'b0;
      sfr_write(8'hD7, 8'h83);
      cycles(1);
      cmp("oscillator enable", 16'h0001, 16'(osc_enable_o));
      wait_lock();
      cmp("lock flag", 16'h0001, 16'(rdata[6]));
      end_sim();
   end

   // The tests need about 20000 cycles; a hang is cut short well beyond that.
   initial begin
      #3200000;
      num_errors++;
      end_sim();
   end
endmodule
